// ### pio_ctrl_model.sv
/* controller model: writes output bytes, strobes exchanges, reads fail-safe area
   assumes the bench calls its tasks one at a time */
`timescale 1ns/100ps
`default_nettype none
module pio_ctrl_model (
  input wire logic clk,
  output var pio_pkg::pio_out_wr_t out_wr,
  output var logic cycle_strobe,
  output var logic [2:0] fs_rd_offset,
  input wire logic [7:0] fs_rd_data
);
  initial begin
    out_wr = '0;
    cycle_strobe = 1'b0;
    fs_rd_offset = 3'h0;
  end
  task automatic wr(input logic s4, input logic [2:0] o, input logic [7:0] d);
    @(posedge clk);
    #1 out_wr = {1'b1, s4, o, d};
    @(posedge clk);
    #1 out_wr.valid = 1'b0;
  endtask
  task automatic strobe();
    @(posedge clk);
    #1 cycle_strobe = 1'b1;
    @(posedge clk);
    #1 cycle_strobe = 1'b0;
  endtask
  task automatic rd(input logic [2:0] o, output logic [7:0] d);
    @(posedge clk);
    #1 fs_rd_offset = o;
    @(posedge clk);
    #1 d = fs_rd_data;
  endtask
endmodule
`default_nettype wire

// ### pio_image.sv
/*
 * Panel I/O process image: slot 2 lamp bytes, slot 4 output bytes and the
 * slot 5 fail-safe status byte, refreshed once per cyclic exchange.
 * Assumes the exchange logic gives one cycle_strobe per data cycle, on clk,
 * and contact pins and fault flags come asynchronously from the panel.
 * Byte writes may arrive in any order between strobes; out-of-range
 * offsets are dropped. Pair mode code 3 is treated as off. Pin changes
 * reach the status byte two clocks after they are sampled, so a strobe
 * only sees the levels that were sampled two clocks before it.
 */
`timescale 1ns/100ps
`default_nettype none

module pio_image #(
  parameter int unsigned LAMPS = 16,
  parameter int unsigned DOUTS = 16,
  parameter int unsigned DINS = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_strobe,
  input wire pio_pkg::pio_out_wr_t out_wr,
  input wire pio_pkg::pio_pair_mode_t mode_pair_a,
  input wire pio_pkg::pio_pair_mode_t mode_pair_b,
  input wire pio_pkg::pio_pair_in_t safe_input_pair_a,
  input wire pio_pkg::pio_pair_in_t safe_input_pair_b,
  input wire logic fault_pair_a,
  input wire logic fault_pair_b,
  input wire logic [DINS-1:0] din_pins,
  input wire logic [2:0] fs_rd_offset,
  output logic [LAMPS-1:0] lamp_red,
  output logic [LAMPS-1:0] lamp_green,
  output logic [LAMPS-1:0] lamp_blue,
  output logic [DOUTS-1:0] dout,
  output logic [DINS-1:0] din_image,
  output logic [7:0] safety_switch_status,
  output logic [7:0] fs_rd_data
);

  // ************************************************************
  // colour decode
  // ************************************************************
  function automatic logic [2:0] pio_lamp_rgb(input logic r, input logic g, input logic b);
    logic [2:0] res;
    res = 3'h0;
    case ({r, g, b})
      3'b100: res = 3'b100;
      3'b010: res = 3'b010;
      3'b001: res = 3'b001;
      3'b110: res = 3'b110;
      3'b111: res = 3'b111;
      default: res = 3'b000;
    endcase
    return res;
  endfunction

  // pair takes part in evaluation; code 3 counts as off
  function automatic logic pio_pair_on(input pio_pkg::pio_pair_mode_t m);
    logic on;
    on = 1'b0;
    case (m)
      pio_pkg::PIO_PAIR_SINGLE: on = 1'b1;
      pio_pkg::PIO_PAIR_DUAL: on = 1'b1;
      default: on = 1'b0;
    endcase
    return on;
  endfunction

  // released button: both channels closed and no fault
  function automatic logic pio_button_free(input logic [1:0] p, input logic f);
    logic free;
    free = p[0] & p[1] & ~f;
    return free;
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [DINS-1:0] din_s1_q;
  logic [DINS-1:0] din_s2_q;

  // contacts and fault flags, two stages before evaluation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {fault_pair_b, fault_pair_a, safe_input_pair_b, safe_input_pair_a};
      sync2_q <= sync1_q;
    end
  end

  // standard digital inputs, two stages before the image
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= din_pins;
      din_s2_q <= din_s1_q;
    end
  end

  logic [1:0] pa_s;
  logic [1:0] pb_s;
  logic fa_s;
  logic fb_s;
  assign pa_s = sync2_q[1:0];
  assign pb_s = sync2_q[3:2];
  assign fa_s = sync2_q[4];
  assign fb_s = sync2_q[5];

  // ************************************************************
  // output image bytes
  // ************************************************************
  logic [7:0] lamp_q [pio_pkg::LAMP_BYTES];
  logic [7:0] dout_q [pio_pkg::DOUT_BYTES];
  logic lamp_we;
  logic dout_we;

  // out-of-range offsets fall through, byte dropped
  assign lamp_we = out_wr.valid && !out_wr.slot4 &&
    (out_wr.offset <= pio_pkg::OFS_LAMP_BLUE_24_31);
  assign dout_we = out_wr.valid && out_wr.slot4 &&
    (out_wr.offset <= pio_pkg::OFS_SWITCHED_OUTPUTS_24_31);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < pio_pkg::LAMP_BYTES; i++) begin
        lamp_q[i] <= pio_pkg::RST_LAMP;
      end
    end else if (lamp_we) begin
      lamp_q[out_wr.offset] <= out_wr.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < pio_pkg::DOUT_BYTES; i++) begin
        dout_q[i] <= pio_pkg::RST_DOUT;
      end
    end else if (dout_we) begin
      dout_q[out_wr.offset[0]] <= out_wr.data;
    end
  end

  // ************************************************************
  // lamp and output drive, applied at the cycle boundary
  // ************************************************************
  logic [LAMPS-1:0] red_d;
  logic [LAMPS-1:0] green_d;
  logic [LAMPS-1:0] blue_d;
  logic [DOUTS-1:0] dout_d;

  // lamp n takes bit n%8 of one red, green, blue byte triple
  genvar gl;
  generate
    for (gl = 0; gl < LAMPS; gl++) begin : g_lamp
      localparam int unsigned GRP = (gl / 8) * 3;
      localparam int unsigned BIT = gl % 8;
      assign {red_d[gl], green_d[gl], blue_d[gl]} =
        pio_lamp_rgb(lamp_q[GRP][BIT], lamp_q[GRP+1][BIT], lamp_q[GRP+2][BIT]);
    end
    for (gl = 0; gl < DOUTS; gl++) begin : g_dout
      assign dout_d[gl] = dout_q[gl / 8][gl % 8];
    end
  endgenerate

  // whole image switches at once, never half a write sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lamp_red <= '0;
      lamp_green <= '0;
      lamp_blue <= '0;
    end else if (cycle_strobe) begin
      lamp_red <= red_d;
      lamp_green <= green_d;
      lamp_blue <= blue_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout <= '0;
    end else if (cycle_strobe) begin
      dout <= dout_d;
    end
  end

  // ************************************************************
  // standard input image
  // ************************************************************
  // inputs claimed by an active pair leave the standard image
  logic [DINS-1:0] safe_mask;
  always_comb begin
    safe_mask = '0;
    if (pio_pair_on(mode_pair_a)) begin
      safe_mask[1:0] = 2'b11;
    end
    if (pio_pair_on(mode_pair_b)) begin
      safe_mask[3:2] = 2'b11;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_image <= '0;
    end else if (cycle_strobe) begin
      din_image <= din_s2_q & ~safe_mask;
    end
  end

  // ************************************************************
  // fail-safe status evaluation
  // ************************************************************
  logic [7:0] status_a_d;
  logic [7:0] status_b_d;
  logic [7:0] status_d;

  // first pair: contacts on bits 5:4 or button on bit 0
  always_comb begin
    status_a_d = 8'h00;
    case (mode_pair_a)
      pio_pkg::PIO_PAIR_SINGLE: begin
        status_a_d[pio_pkg::BIT_CONTACT_A0 +: 2] = pa_s;
      end
      pio_pkg::PIO_PAIR_DUAL: begin
        status_a_d[pio_pkg::BIT_ESTOP_A] = pio_button_free(pa_s, fa_s);
      end
      default: begin
      end
    endcase
  end

  // second pair: button on bit 1 only beside a first-pair button
  always_comb begin
    status_b_d = 8'h00;
    case (mode_pair_b)
      pio_pkg::PIO_PAIR_SINGLE: begin
        status_b_d[pio_pkg::BIT_CONTACT_B0 +: 2] = pb_s;
      end
      pio_pkg::PIO_PAIR_DUAL: begin
        if (mode_pair_a == pio_pkg::PIO_PAIR_DUAL) begin
          status_b_d[pio_pkg::BIT_ESTOP_B] = pio_button_free(pb_s, fb_s);
        end
      end
      default: begin
      end
    endcase
  end

  // the pairs own disjoint bits, so merging is a plain or
  assign status_d = status_a_d | status_b_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      safety_switch_status <= pio_pkg::RST_STATUS;
    end else if (cycle_strobe) begin
      safety_switch_status <= status_d;
    end
  end

  // ************************************************************
  // fail-safe input area read, five bytes from base x
  // ************************************************************
  logic [7:0] fs_rd_d;
  // only byte 0 carries data; the other four input bytes read zero
  always_comb begin
    fs_rd_d = 8'h00;
    case (fs_rd_offset)
      pio_pkg::OFS_SAFETY_SWITCH_STATUS: fs_rd_d = safety_switch_status;
      default: fs_rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fs_rd_data <= 8'h00;
    end else begin
      fs_rd_data <= fs_rd_d;
    end
  end

endmodule
`default_nettype wire

// ### pio_image_assertions.sv
/* checker: timing and mapping relations at the ports of pio_image
   assumes one clock, active-low async reset, bound by module name */
`timescale 1ns/100ps
`default_nettype none
module pio_image_assertions #(
  parameter int unsigned LAMPS = 16,
  parameter int unsigned DOUTS = 16,
  parameter int unsigned DINS = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycle_strobe,
  input wire pio_pkg::pio_pair_mode_t mode_pair_a,
  input wire pio_pkg::pio_pair_mode_t mode_pair_b,
  input wire pio_pkg::pio_pair_in_t safe_input_pair_a,
  input wire pio_pkg::pio_pair_in_t safe_input_pair_b,
  input wire logic fault_pair_a,
  input wire logic fault_pair_b,
  input wire logic [2:0] fs_rd_offset,
  input wire logic [LAMPS-1:0] lamp_red,
  input wire logic [LAMPS-1:0] lamp_green,
  input wire logic [LAMPS-1:0] lamp_blue,
  input wire logic [DOUTS-1:0] dout,
  input wire logic [DINS-1:0] din_image,
  input wire logic [7:0] safety_switch_status,
  input wire logic [7:0] fs_rd_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic st, a1, a2, b1, b2;
  logic [7:0] s;
  assign st = cycle_strobe;
  assign s = safety_switch_status;
  assign a1 = mode_pair_a == pio_pkg::PIO_PAIR_SINGLE;
  assign a2 = mode_pair_a == pio_pkg::PIO_PAIR_DUAL;
  assign b1 = mode_pair_b == pio_pkg::PIO_PAIR_SINGLE;
  assign b2 = mode_pair_b == pio_pkg::PIO_PAIR_DUAL;
  chk_image_hold: assert property (!st |=> $stable(s) && $stable(lamp_red) && $stable(dout))
    else $error("image moved without strobe");
  chk_unused_zero: assert property (s[3:2] == 2'b00)
    else $error("unused status bits set");
  chk_off_silent: assert property (st && !a1 && !a2 && !b1 && !b2 |=> s == 8'h00)
    else $error("status reported with pairs off");
  chk_single_a: assert property (st && a1 |=> s[5:4] == $past(safe_input_pair_a, 3))
    else $error("pair a contacts wrong");
  chk_dual_a: assert property (st && a2 |=> {s[5:4], s[0]} ==
    {2'b00, $past(&safe_input_pair_a && !fault_pair_a, 3)}) else $error("button a wrong");
  chk_single_b: assert property (st && b1 |=> s[7:6] == $past(safe_input_pair_b, 3))
    else $error("pair b contacts wrong");
  chk_dual_b: assert property (st && a2 && b2 |=>
    s[1] == $past(&safe_input_pair_b && !fault_pair_b, 3)) else $error("button b wrong");
  chk_bit1_unused: assert property (st && !(a2 && b2) |=> !s[1])
    else $error("bit 1 set outside dual pair");
  chk_lamp_decode: assert property ((lamp_blue & (lamp_red ^ lamp_green)) == '0)
    else $error("lamp shows an off combination");
  chk_din_mask: assert property (st && (a1 || a2) |=> din_image[1:0] == 2'b00)
    else $error("safe inputs leak into image");
  chk_fs_status: assert property (fs_rd_offset == 3'h0 |=> fs_rd_data == $past(s))
    else $error("fail-safe byte 0 wrong");
  chk_fs_rest: assert property (fs_rd_offset inside {[3'h1:3'h4]} |=> fs_rd_data == 8'h00)
    else $error("fail-safe bytes 1 to 4 not zero");
endmodule
bind pio_image pio_image_assertions #(.LAMPS(LAMPS), .DOUTS(DOUTS), .DINS(DINS)) u_chk (.*);
`default_nettype wire

// ### pio_pkg.sv
/*
 * Package for the panel I/O image block: image byte offsets, field positions,
 * reset values, evaluation modes and carrier structs.
 * Assumes a single 200 MHz clock domain and an active-low asynchronous reset.
 */
package pio_pkg;

  // ************************************************************
  // image geometry
  // ************************************************************
  localparam int unsigned LAMP_BYTES = 6;
  localparam int unsigned DOUT_BYTES = 2;
  localparam int unsigned FS_IN_BYTES = 5;
  localparam int unsigned FS_OUT_BYTES = 4;

  // slot 2 output byte offsets
  localparam logic [2:0] OFS_LAMP_RED_16_23 = 3'h0;
  localparam logic [2:0] OFS_LAMP_GREEN_16_23 = 3'h1;
  localparam logic [2:0] OFS_LAMP_BLUE_16_23 = 3'h2;
  localparam logic [2:0] OFS_LAMP_RED_24_31 = 3'h3;
  localparam logic [2:0] OFS_LAMP_GREEN_24_31 = 3'h4;
  localparam logic [2:0] OFS_LAMP_BLUE_24_31 = 3'h5;
  // slot 4 output byte offsets
  localparam logic [2:0] OFS_SWITCHED_OUTPUTS_16_23 = 3'h0;
  localparam logic [2:0] OFS_SWITCHED_OUTPUTS_24_31 = 3'h1;
  // slot 5 input byte offset
  localparam logic [2:0] OFS_SAFETY_SWITCH_STATUS = 3'h0;

  // ************************************************************
  // status byte fields
  // ************************************************************
  localparam int unsigned BIT_ESTOP_A = 0;
  localparam int unsigned BIT_ESTOP_B = 1;
  localparam int unsigned BIT_CONTACT_A0 = 4;
  localparam int unsigned BIT_CONTACT_B0 = 6;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_LAMP = 8'h00;
  localparam logic [7:0] RST_DOUT = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PIO_PAIR_OFF,
    PIO_PAIR_SINGLE,
    PIO_PAIR_DUAL
  } pio_pair_mode_t;

  typedef enum logic [2:0] {
    PIO_LAMP_OFF,
    PIO_LAMP_RED,
    PIO_LAMP_GREEN,
    PIO_LAMP_BLUE,
    PIO_LAMP_YELLOW,
    PIO_LAMP_WHITE
  } pio_colour_t;

  // one cyclic exchange write of an output slot byte
  typedef struct packed {
    logic       valid;
    logic       slot4;
    logic [2:0] offset;
    logic [7:0] data;
  } pio_out_wr_t;

  // raw contact levels of one safe input pair
  typedef struct packed {
    logic ch1;
    logic ch0;
  } pio_pair_in_t;

endpackage

// ### test_panel_io_safety_image.sv
/* testbench for pio_image: lamp decode, outputs, status modes, fail-safe reads
   assumes pio_ctrl_model as controller and the bound checker */
`timescale 1ns/100ps
`default_nettype none
module test_panel_io_safety_image;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  pio_pkg::pio_pair_mode_t ma = pio_pkg::PIO_PAIR_OFF, mb = pio_pkg::PIO_PAIR_OFF;
  pio_pkg::pio_pair_in_t pa = '0, pb = '0;
  logic fa = 1'b0, fb = 1'b0, strobe;
  pio_pkg::pio_out_wr_t wr;
  logic [2:0] ofs;
  logic [15:0] dpin = '0, red, grn, blu, dout, dimg, r, g, u, m;
  logic [7:0] stat, fsd, v;
  logic [7:0] b [8] = '{8'hf0, 8'hcc, 8'haa, 8'h0f, 8'h33, 8'h55, 8'hff, 8'h00};
  logic [31:0] seed = 32'h1774_6b4c;
  int failures = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pio_ctrl_model ctl (.clk(clk), .out_wr(wr), .cycle_strobe(strobe), .fs_rd_offset(ofs),
    .fs_rd_data(fsd));
  pio_image dut (.clk(clk), .nrst(nrst), .cycle_strobe(strobe), .out_wr(wr),
    .mode_pair_a(ma), .mode_pair_b(mb), .safe_input_pair_a(pa), .safe_input_pair_b(pb),
    .fault_pair_a(fa), .fault_pair_b(fb), .din_pins(dpin), .fs_rd_offset(ofs),
    .lamp_red(red), .lamp_green(grn), .lamp_blue(blu), .dout(dout), .din_image(dimg),
    .safety_switch_status(stat), .fs_rd_data(fsd));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic en(logic [1:0] x);
    return x == 2'h1 || x == 2'h2;
  endfunction
  function automatic logic [7:0] exp_stat(logic [1:0] a, logic [1:0] c);
    logic [7:0] s;
    s = 8'h00;
    if (a == 2'h1) s[5:4] = pa;
    if (a == 2'h2) s[0] = &pa & ~fa;
    if (c == 2'h1) s[7:6] = pb;
    if (a == 2'h2 && c == 2'h2) s[1] = &pb & ~fb;
    return s;
  endfunction
  task automatic cmp(logic [15:0] got, logic [15:0] exp, string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end
  initial begin
    tick(4);
    nrst = 1'b1;
    cmp(red | grn | blu | dout | dimg, 16'h0000, "reset outputs");
    cmp({stat, fsd}, 16'h0000, "reset status");
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 8; k++) begin
        seed = lfsr(seed);
        if (i > 0) b[k] = seed[7:0];
        ctl.wr(k > 5, 3'(k > 5 ? k - 6 : k), b[k]);
      end
      ctl.wr(1'b0, 3'h6, seed[15:8]);
      ctl.wr(1'b1, 3'h2, seed[23:16]);
      ctl.strobe();
      tick(2);
      r = {b[3], b[0]};
      g = {b[4], b[1]};
      u = {b[5], b[2]};
      m = ~(u & (r ^ g));
      cmp(red, r & m, "red");
      cmp(grn, g & m, "green");
      cmp(blu, u & m, "blue");
      cmp(dout, {b[7], b[6]}, "dout");
    end
    $display("lamp and output test done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      ma = pio_pkg::pio_pair_mode_t'(i < 16 ? 2'(i) : seed[1:0]);
      mb = pio_pkg::pio_pair_mode_t'(i < 16 ? 2'(i / 4) : seed[3:2]);
      {pa, pb, fa, fb} = seed[9:4];
      dpin = seed[31:16];
      tick(5);
      ctl.strobe();
      tick(2);
      cmp(16'(stat), 16'(exp_stat(ma, mb)), "status");
      m = dpin;
      if (en(ma)) m[1:0] = 2'b00;
      if (en(mb)) m[3:2] = 2'b00;
      cmp(dimg, m, "input image");
      for (int k = 0; k < 5; k++) begin
        ctl.rd(3'(k), v);
        cmp(16'(v), k == 0 ? 16'(exp_stat(ma, mb)) : 16'h0000, "fail-safe byte");
      end
    end
    $display("status test done");
    results();
  end
endmodule
`default_nettype wire
